// file: rtl/trc_top.sv
// Reset sequencing, RAM test, serial self-init, host gating, inhibit, activity and time tags
`timescale 1ns/1ps
`default_nettype none
`include "trc_regs.svh"
// Functional notes
// - Reset completes two clock edges after release
// - Software reset via status register write
// - Inhibit bus transmit by pin or bit
// - Test whole RAM when skip pin low
// - Skip RAM test when pin high
// - Sample enable at release, copy serial memory
// - Low range select: span up to 0x1fff
// - High range select: span up to 0x07ff
// - Range select ignored without self-init enable
// - Ready low during init or test
// - Not ready: writes blocked, reads return status
// - Activity high while remote terminal busy
// - Monitor bit adds monitor activity to output
// - Separate remote and monitor tag counters
// - Remote counter internal or external clock
// - Monitor counter has own clock choice
// - Self-init reads over dedicated serial port
module trc_top
  import trc_pkg::*;
#(
  parameter logic [12:0] RAM_LAST = 13'h1fff,
  parameter logic [7:0] SPI_HALF = 8'h04
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic master_reset_n,
  input wire logic ram_test_skip,
  input wire logic self_init_enable,
  input wire logic short_init_range,
  input wire logic bus_a_tx_inhibit,
  input wire logic bus_b_tx_inhibit,
  input wire logic rt_tag_clock_in,
  input wire logic monitor_tag_clock_in,
  input wire logic rt_busy,
  input wire logic mt_busy,
  input wire trc_host_req_t host_in,
  output logic host_ack,
  output logic [15:0] host_rdata,
  output trc_mem_req_t mem_out,
  input wire logic [15:0] mem_rdata,
  output logic ready,
  output logic activity,
  output logic tx_inhibit_a,
  output logic tx_inhibit_b,
  output logic ee_cs_n,
  output logic ee_sck,
  output logic ee_mosi,
  input wire logic ee_miso,
  output logic [15:0] rt_tag_count,
  output logic [15:0] mt_tag_count
);

  // Synchroniser bit order
  localparam int S_MR = 0;
  localparam int S_SKIP = 1;
  localparam int S_AUTO = 2;
  localparam int S_SHORT = 3;
  localparam int S_INHA = 4;
  localparam int S_INHB = 5;
  localparam int S_MISO = 6;

  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
    trc_phase_t phase;
    logic [1:0] settle;
    logic [12:0] addr;
    logic [12:0] last;
    logic auto_en;
    logic skip_test;
    logic test_fail;
    logic [15:0] mcfg1;
    logic cs_n;
    logic sck;
    logic mosi;
    logic [7:0] div;
    logic [4:0] bits;
    logic hdr;
    logic [23:0] hdr_sh;
    logic [15:0] word;
    trc_mem_req_t mem;
    logic p1;
    logic p2;
    logic p_local;
    logic [15:0] local_val;
    logic [15:0] rdata;
    logic ack;
    logic act;
    logic inh_a;
    logic inh_b;
  } trc_state_t;

  trc_state_t st_r;
  trc_state_t st_nxt;
  logic [15:0] status_word;
  logic [15:0] test_pat;
  logic [15:0] new_word;

  // Status view, also the only read answer while not ready
  always_comb begin
    status_word = 16'h0000;
    status_word[`TRC_MSTAT_TEST_FAIL] = st_r.test_fail;
    status_word[`TRC_MSTAT_READY] = (st_r.phase == TRC_RUN);
    status_word[`TRC_MSTAT_TEST_BUSY] = (st_r.phase == TRC_TEST_WR) || (st_r.phase == TRC_TEST_RD) ||
                                        (st_r.phase == TRC_TEST_WAIT) || (st_r.phase == TRC_TEST_CHK);
    status_word[`TRC_MSTAT_INIT_BUSY] = (st_r.phase == TRC_INIT) || (st_r.phase == TRC_SETTLE);
  end

  // Pattern depends on address so stuck address lines are caught
  assign test_pat = {3'b000, st_r.addr} ^ `TRC_TEST_SEED;
  assign new_word = {st_r.word[14:0], st_r.s2[S_MISO]};

  // Next state of the whole block
  always_comb begin
    st_nxt = st_r;
    st_nxt.mem.req = 1'b0;
    st_nxt.mem.we = 1'b0;
    st_nxt.ack = 1'b0;
    st_nxt.inh_a = st_r.s2[S_INHA] | st_r.mcfg1[`TRC_MCFG1_INH_A];
    st_nxt.inh_b = st_r.s2[S_INHB] | st_r.mcfg1[`TRC_MCFG1_INH_B];
    st_nxt.act = rt_busy | (st_r.mcfg1[`TRC_MCFG1_MONITOR_ACTIVITY_INCLUDE] & mt_busy);

    // Host answer pipeline: stage one waits for RAM, stage two returns data
    st_nxt.p2 = st_r.p1;
    st_nxt.p1 = 1'b0;
    if (st_r.p2) begin
      st_nxt.rdata = st_r.p_local ? st_r.local_val : mem_rdata;
      st_nxt.ack = 1'b1;
    end

    case (st_r.phase)
      TRC_HOLD: begin
        st_nxt.settle = 2'd0;
        if (st_r.s2[S_MR]) begin
          st_nxt.auto_en = st_r.s2[S_AUTO];
          st_nxt.skip_test = st_r.s2[S_SKIP];
          st_nxt.last = (st_r.s2[S_AUTO] && st_r.s2[S_SHORT]) ? `TRC_SHORT_LAST : `TRC_FULL_LAST;
          st_nxt.phase = TRC_SETTLE;
        end
      end
      TRC_SETTLE: begin
        if (st_r.settle == `TRC_SETTLE_EDGES - 2'd1) begin
          st_nxt.addr = 13'h0000;
          if (!st_r.skip_test) begin
            st_nxt.phase = TRC_TEST_WR;
          end else if (st_r.auto_en) begin
            st_nxt.phase = TRC_INIT;
          end else begin
            st_nxt.phase = TRC_RUN;
          end
        end else begin
          st_nxt.settle = st_r.settle + 2'd1;
        end
      end
      TRC_TEST_WR: begin
        st_nxt.mem.req = 1'b1;
        st_nxt.mem.we = 1'b1;
        st_nxt.mem.addr = st_r.addr;
        st_nxt.mem.wdata = test_pat;
        st_nxt.addr = st_r.addr + 13'h0001;
        if (st_r.addr == RAM_LAST) begin
          st_nxt.addr = 13'h0000;
          st_nxt.phase = TRC_TEST_RD;
        end
      end
      TRC_TEST_RD: begin
        st_nxt.mem.req = 1'b1;
        st_nxt.mem.addr = st_r.addr;
        st_nxt.phase = TRC_TEST_WAIT;
      end
      TRC_TEST_WAIT: begin
        st_nxt.phase = TRC_TEST_CHK;
      end
      TRC_TEST_CHK: begin
        // Failure is sticky; the sequence still runs to the end
        if (mem_rdata != test_pat) begin
          st_nxt.test_fail = 1'b1;
        end
        st_nxt.addr = st_r.addr + 13'h0001;
        st_nxt.phase = TRC_TEST_RD;
        if (st_r.addr == RAM_LAST) begin
          st_nxt.addr = 13'h0000;
          st_nxt.phase = st_r.auto_en ? TRC_INIT : TRC_RUN;
        end
      end
      TRC_INIT: begin
        // serial read, mode 0, header then words
        if (st_r.cs_n) begin
          st_nxt.cs_n = 1'b0;
          st_nxt.sck = 1'b0;
          st_nxt.mosi = 1'(`TRC_EE_HEADER >> `TRC_EE_HDR_LAST);
          st_nxt.hdr_sh = `TRC_EE_HEADER << 1;
          st_nxt.hdr = 1'b1;
          st_nxt.bits = 5'd0;
          st_nxt.div = SPI_HALF - 8'h01;
        end else if (st_r.div != 8'h00) begin
          st_nxt.div = st_r.div - 8'h01;
        end else begin
          st_nxt.div = SPI_HALF - 8'h01;
          st_nxt.sck = ~st_r.sck;
          if (!st_r.sck) begin
            st_nxt.bits = st_r.bits + 5'd1;
            if (st_r.hdr) begin
              if (st_r.bits == `TRC_EE_HDR_LAST) begin
                st_nxt.hdr = 1'b0;
                st_nxt.bits = 5'd0;
              end
            end else begin
              st_nxt.word = new_word;
              if (st_r.bits == `TRC_EE_WORD_LAST) begin
                st_nxt.bits = 5'd0;
                // words land in MCFG1 or RAM; the word at the status address is dropped
                if (st_r.addr == `TRC_ADDR_MCFG1) begin
                  st_nxt.mcfg1 = new_word;
                end else if (st_r.addr != `TRC_ADDR_MSTAT) begin
                  st_nxt.mem.req = 1'b1;
                  st_nxt.mem.we = 1'b1;
                  st_nxt.mem.addr = st_r.addr;
                  st_nxt.mem.wdata = new_word;
                end
                st_nxt.addr = st_r.addr + 13'h0001;
                if (st_r.addr == st_r.last) begin
                  st_nxt.cs_n = 1'b1;
                  st_nxt.sck = 1'b0;
                  st_nxt.phase = TRC_RUN;
                end
              end
            end
          end else begin
            st_nxt.mosi = st_r.hdr_sh[23];
            st_nxt.hdr_sh = {st_r.hdr_sh[22:0], 1'b0};
          end
        end
      end
      default: begin
      end
    endcase

    // Host access; one request at a time, ignored while an answer is pending
    if (host_in.req && !st_r.p1 && !st_r.p2) begin
      st_nxt.p1 = 1'b1;
      st_nxt.p_local = 1'b1;
      st_nxt.local_val = status_word;
      // not ready: no write, status read
      if (st_r.phase == TRC_RUN) begin
        if (host_in.addr == `TRC_ADDR_MCFG1) begin
          st_nxt.local_val = st_r.mcfg1;
          if (host_in.we) begin
            st_nxt.mcfg1 = host_in.wdata;
          end
        end else if (host_in.addr == `TRC_ADDR_MSTAT) begin
          if (host_in.we && host_in.wdata[`TRC_MSTAT_SOFT_RST]) begin
            st_nxt.phase = TRC_SETTLE;
            st_nxt.settle = 2'd0;
            st_nxt.mcfg1 = `TRC_MCFG1_RESET;
            st_nxt.test_fail = 1'b0;
          end
        end else begin
          st_nxt.p_local = 1'b0;
          st_nxt.mem.req = 1'b1;
          st_nxt.mem.we = host_in.we;
          st_nxt.mem.addr = host_in.addr;
          st_nxt.mem.wdata = host_in.wdata;
        end
      end
    end

    // Master reset pin low wipes all control state but the synchronisers back to hold; the tag counters keep counting
    if (!st_r.s2[S_MR]) begin
      st_nxt = '0;
      st_nxt.phase = TRC_HOLD;
      st_nxt.cs_n = 1'b1;
      st_nxt.mcfg1 = `TRC_MCFG1_RESET;
    end
    // Synchronisers keep sampling through master reset, so straps are current at release
    st_nxt.s1 = {ee_miso, bus_b_tx_inhibit, bus_a_tx_inhibit, short_init_range,
                 self_init_enable, ram_test_skip, master_reset_n};
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.phase <= TRC_HOLD;
      st_r.cs_n <= 1'b1;
      st_r.mcfg1 <= `TRC_MCFG1_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ready = (st_r.phase == TRC_RUN);
  assign host_ack = st_r.ack;
  assign host_rdata = st_r.rdata;
  assign mem_out = st_r.mem;
  assign activity = st_r.act;
  assign tx_inhibit_a = st_r.inh_a;
  assign tx_inhibit_b = st_r.inh_b;
  assign ee_cs_n = st_r.cs_n;
  assign ee_sck = st_r.sck;
  assign ee_mosi = st_r.mosi;

  trc_tag_counter #(.WIDTH(16)) u_rt_tag (
    .clk(clk),
    .sys_rst(sys_rst),
    .ext_clk_in(rt_tag_clock_in),
    .use_ext(st_r.mcfg1[`TRC_MCFG1_RT_EXT]),
    .div_sel(st_r.mcfg1[`TRC_MCFG1_RT_DIV_LO +: 3]),
    .count(rt_tag_count)
  );

  trc_tag_counter #(.WIDTH(16)) u_mt_tag (
    .clk(clk),
    .sys_rst(sys_rst),
    .ext_clk_in(monitor_tag_clock_in),
    .use_ext(st_r.mcfg1[`TRC_MCFG1_MT_EXT]),
    .div_sel(st_r.mcfg1[`TRC_MCFG1_MT_DIV_LO +: 3]),
    .count(mt_tag_count)
  );

endmodule
`default_nettype wire

// file: rtl/trc_regs.svh
// Register addresses, field positions, reset values and timing counts of the reset and init control
`ifndef TRC_REGS_SVH
`define TRC_REGS_SVH

// Register word addresses in the shared register and RAM space
`define TRC_ADDR_MCFG1 13'h0000
`define TRC_ADDR_MSTAT 13'h0001

// Master configuration register one fields
`define TRC_MCFG1_RESET 16'h0000
`define TRC_MCFG1_MONITOR_ACTIVITY_INCLUDE 1
`define TRC_MCFG1_INH_A 2
`define TRC_MCFG1_INH_B 3
`define TRC_MCFG1_RT_EXT 4
`define TRC_MCFG1_RT_DIV_LO 5
`define TRC_MCFG1_MT_EXT 8
`define TRC_MCFG1_MT_DIV_LO 9

// Master status and reset register fields
`define TRC_MSTAT_SOFT_RST 0
`define TRC_MSTAT_TEST_FAIL 1
`define TRC_MSTAT_READY 2
`define TRC_MSTAT_TEST_BUSY 3
`define TRC_MSTAT_INIT_BUSY 4

// Last word address of each self-initialization span
`define TRC_FULL_LAST 13'h1fff
`define TRC_SHORT_LAST 13'h07ff

// Clock edges needed after master reset release
`define TRC_SETTLE_EDGES 2'd2

// Serial memory read header: command byte then 16-bit start address
`define TRC_EE_HEADER 24'h030000
`define TRC_EE_HDR_LAST 5'd23
`define TRC_EE_WORD_LAST 5'd15

// Seed mixed into the RAM test pattern
`define TRC_TEST_SEED 16'ha5a5

`endif

// file: rtl/trc_pkg.sv
// Types shared by the reset and init control and its time tag counters
`default_nettype none
package trc_pkg;

  typedef enum logic [2:0] {
    TRC_HOLD,
    TRC_SETTLE,
    TRC_TEST_WR,
    TRC_TEST_RD,
    TRC_TEST_WAIT,
    TRC_TEST_CHK,
    TRC_INIT,
    TRC_RUN
  } trc_phase_t;

  // Host access request as seen by the block
  typedef struct packed {
    logic req;
    logic we;
    logic [12:0] addr;
    logic [15:0] wdata;
  } trc_host_req_t;

  // Access toward the internal RAM
  typedef struct packed {
    logic req;
    logic we;
    logic [12:0] addr;
    logic [15:0] wdata;
  } trc_mem_req_t;

endpackage
`default_nettype wire

// file: rtl/trc_tag_counter.sv
// Time tag counter with selectable internal rate or external tick input
`timescale 1ns/1ps
`default_nettype none
module trc_tag_counter
  import trc_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter logic [15:0] BASE_DIV = 16'h0064
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ext_clk_in,
  input wire logic use_ext,
  input wire logic [2:0] div_sel,
  output logic [WIDTH-1:0] count
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [15:0] pre;
    logic [WIDTH-1:0] cnt;
  } trc_tag_state_t;

  trc_tag_state_t st_r;
  trc_tag_state_t st_nxt;
  logic [15:0] term;

  // Internal rate is the base rate halved per select step
  assign term = (BASE_DIV << div_sel) - 16'h0001;
  assign count = st_r.cnt;

  // Next state: pin synchroniser, prescaler and the counter itself
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = ext_clk_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (use_ext) begin
      st_nxt.pre = 16'h0000;
      if (st_r.s2 && !st_r.s3) begin
        st_nxt.cnt = st_r.cnt + 1'b1;
      end
    end else if (st_r.pre >= term) begin
      st_nxt.pre = 16'h0000;
      st_nxt.cnt = st_r.cnt + 1'b1;
    end else begin
      st_nxt.pre = st_r.pre + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule
`default_nettype wire

// file: dv/trc_top_assertions.sv
// Port-level checker for the reset and init control
`timescale 1ns/1ps
`default_nettype none
module trc_top_assertions
  import trc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic master_reset_n,
  input wire logic self_init_enable,
  input wire logic short_init_range,
  input wire logic bus_a_tx_inhibit,
  input wire logic bus_b_tx_inhibit,
  input wire logic rt_busy,
  input wire logic mt_busy,
  input wire trc_host_req_t host_in,
  input wire logic host_ack,
  input wire logic [15:0] host_rdata,
  input wire trc_mem_req_t mem_out,
  input wire logic ready,
  input wire logic activity,
  input wire logic tx_inhibit_a,
  input wire logic tx_inhibit_b,
  input wire logic ee_cs_n
);
  logic [1:0] pend_r;
  logic auto_r;
  logic [12:0] last_r;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Host answer window, so refused requests do not count
  always_ff @(posedge clk) begin
    if (sys_rst) pend_r <= 2'h0;
    else if (host_in.req && pend_r == 2'h0) pend_r <= 2'h2;
    else if (pend_r != 2'h0) pend_r <= pend_r - 2'h1;
  end
  // Straps follow the pins while reset is held, so the release value stays
  always_ff @(posedge clk) begin
    if (!master_reset_n) begin
      auto_r <= self_init_enable;
      last_r <= (self_init_enable && short_init_range) ? 13'h07ff : 13'h1fff;
    end
  end
  sequence s_take;
    host_in.req && pend_r == 2'h0;
  endsequence
  sequence s_rel;
    $rose(master_reset_n);
  endsequence
  a_ack_three: assert property (s_take |-> ##3 host_ack) else $error("host answer late");
  a_ack_cause: assert property (host_ack |-> $past(host_in.req, 3)) else $error("stray host answer");
  a_busy_status: assert property (s_take ##0 !ready ##3 !ready |-> host_rdata[2] == 1'b0)
    else $error("busy read not status");
  a_settle_low: assert property (s_rel |-> !ready [*3]) else $error("ready before settle");
  a_reset_low: assert property (!master_reset_n [*4] |=> !ready) else $error("ready in reset");
  a_inh_a: assert property (bus_a_tx_inhibit [*3] |=> tx_inhibit_a) else $error("bus a not inhibited");
  a_inh_b: assert property (bus_b_tx_inhibit [*3] |=> tx_inhibit_b) else $error("bus b not inhibited");
  a_act_rt: assert property (rt_busy |=> activity) else $error("activity missed");
  a_act_idle: assert property (!rt_busy && !mt_busy |=> !activity) else $error("activity stray");
  a_ready_quiet: assert property (ready |-> ee_cs_n) else $error("init while ready");
  a_init_span: assert property (!ready && master_reset_n && mem_out.req |-> mem_out.addr <= last_r)
    else $error("init past span");
  a_ee_idle: assert property (!auto_r && master_reset_n |-> ee_cs_n) else $error("init not enabled");
endmodule
bind trc_top trc_top_assertions trc_top_assertions_i (.*);
`default_nettype wire

// file: dv/trc_far_model.sv
// Far side model: RAM behind the block and the serial init memory
`timescale 1ns/1ps
`default_nettype none
module trc_far_model
  import trc_pkg::*;
(
  input wire logic clk,
  input wire trc_mem_req_t mem_out,
  output logic [15:0] mem_rdata,
  input wire logic corrupt,
  input wire logic ee_cs_n,
  input wire logic ee_sck,
  input wire logic ee_mosi,
  output logic ee_miso,
  output logic [23:0] hdr
);
  logic [15:0] ram [0:8191];
  logic [15:0] w;
  int rise_n = 0;
  int out_n = 0;
  function automatic logic [15:0] ew(input int n);
    return n == 0 ? 16'h000e : 16'h3c00 ^ 16'(n);
  endfunction
  // Data valid one cycle after request, scrambled otherwise; corrupt breaks a test read
  always @(posedge clk) begin
    if (mem_out.req && mem_out.we) ram[mem_out.addr] <= mem_out.wdata;
    if (mem_out.req) mem_rdata <= ram[mem_out.addr] ^ {15'h0000, corrupt};
    else mem_rdata <= ~mem_rdata;
  end
  always @(posedge ee_sck or posedge ee_cs_n) begin
    if (ee_cs_n) rise_n <= 0;
    else begin
      rise_n <= rise_n + 1;
      if (rise_n < 24) hdr <= {hdr[22:0], ee_mosi};
    end
  end
  // Mode 0: next bit is put out on the falling edge
  always @(negedge ee_sck or posedge ee_cs_n) begin
    if (ee_cs_n) out_n <= 0;
    else out_n <= rise_n;
  end
  assign w = ew((out_n - 24) / 16);
  assign ee_miso = (ee_cs_n || out_n < 24) ? 1'b0 : w[15 - (out_n - 24) % 16];
endmodule
`default_nettype wire

// file: dv/trc_top_test.sv
// Self-checking bench for the reset and init control
`timescale 1ns/1ps
`default_nettype none
`define CK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module trc_top_test;
  import trc_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, master_reset_n = 1'b0, ram_test_skip = 1'b1, corrupt = 1'b0;
  logic self_init_enable = 1'b0, short_init_range = 1'b0, rt_busy = 1'b0, mt_busy = 1'b0;
  logic bus_a_tx_inhibit = 1'b0, bus_b_tx_inhibit = 1'b0, rt_tag_clock_in = 1'b0, monitor_tag_clock_in = 1'b0;
  trc_host_req_t host_in = '0;
  trc_mem_req_t mem_out;
  logic host_ack, ready, activity, tx_inhibit_a, tx_inhibit_b, ee_cs_n, ee_sck, ee_mosi, ee_miso;
  logic [15:0] host_rdata, mem_rdata, rt_tag_count, mt_tag_count, q, v, t;
  logic [23:0] hdr;
  int err_count = 0, compares = 0;
  trc_top #(.RAM_LAST(13'h000f), .SPI_HALF(8'h04)) trc_top_i (.*);
  trc_far_model trc_far_model_i (.*);
  initial forever #5 clk = ~clk;
  function automatic logic [15:0] ew(input int n);
    return n == 0 ? 16'h000e : 16'h3c00 ^ 16'(n);
  endfunction
  task automatic stop_test();
    if (err_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic timeout();
    err_count++;
    $display("CHECK FAILED %0t timeout", $time);
    stop_test();
  endtask
  // One host access: pulse request, wait the answer, keep one idle cycle
  task automatic hx(input logic w, input logic [12:0] a, input logic [15:0] d);
    int i;
    host_in = {1'b1, w, a, d};
    @(negedge clk) host_in.req = 1'b0;
    for (i = 0; i < 8 && host_ack !== 1'b1; i++) @(negedge clk);
    if (host_ack !== 1'b1) timeout();
    q = host_rdata;
    @(negedge clk);
  endtask
  task automatic wait_rdy(input int n);
    int i;
    for (i = 0; i < n && ready !== 1'b1; i++) @(negedge clk);
    if (ready !== 1'b1) timeout();
  endtask
  task automatic mr(input logic s, input logic au, input logic sh);
    ram_test_skip = s;
    self_init_enable = au;
    short_init_range = sh;
    master_reset_n = 1'b0;
    repeat (4) @(negedge clk);
    master_reset_n = 1'b1;
    // Host stays off the bus until the synchronised release has reached the block
    repeat (2) @(negedge clk);
  endtask
  initial begin
    int i;
    void'($urandom(48656));
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    mr(1'b1, 1'b0, 1'b1);
    `CK(ready, 1'b0)
    wait_rdy(20);
    `CK(ee_cs_n, 1'b1)
    hx(1'b0, 13'h0001, 16'h0000);
    `CK(q, 16'h0004)
    // Random config against pins and busy inputs
    repeat (8) begin
      v = 16'($urandom) & 16'h000e;
      hx(1'b1, 13'h0000, v);
      hx(1'b0, 13'h0000, 16'h0000);
      `CK(q, v)
      {bus_a_tx_inhibit, bus_b_tx_inhibit, rt_busy, mt_busy} = 4'($urandom);
      repeat (4) @(negedge clk);
      `CK(tx_inhibit_a, bus_a_tx_inhibit | v[2])
      `CK(tx_inhibit_b, bus_b_tx_inhibit | v[3])
      `CK(activity, rt_busy | (v[1] & mt_busy))
    end
    {bus_a_tx_inhibit, bus_b_tx_inhibit, rt_busy, mt_busy} = 4'h0;
    v = 16'($urandom);
    hx(1'b1, 13'h0123, v);
    hx(1'b0, 13'h0123, 16'h0000);
    `CK(q, v)
    // External ticks: five pulses on the selected counter's pin, counted by that counter
    for (int k = 0; k < 2; k++) begin
      hx(1'b1, 13'h0000, k ? 16'h0100 : 16'h0010);
      t = k ? mt_tag_count : rt_tag_count;
      repeat (5) begin
        {monitor_tag_clock_in, rt_tag_clock_in} = k ? 2'b10 : 2'b01;
        repeat (3) @(negedge clk);
        {monitor_tag_clock_in, rt_tag_clock_in} = 2'b00;
        repeat (3) @(negedge clk);
      end
      repeat (4) @(negedge clk);
      `CK((k ? mt_tag_count : rt_tag_count) - t, 16'h0005)
    end
    // Internal rates: remote at select 1 (200 cycles), monitor at select 2 (400 cycles)
    hx(1'b1, 13'h0000, 16'h0420);
    t = rt_tag_count;
    v = mt_tag_count;
    repeat (2000) @(negedge clk);
    `CK(rt_tag_count - t, 16'h000a)
    `CK(mt_tag_count - v, 16'h0005)
    // RAM test: host write dropped, reads give status
    v = 16'($urandom);
    hx(1'b1, 13'h0123, 16'h0000);
    mr(1'b0, 1'b0, 1'b0);
    hx(1'b1, 13'h0123, v);
    hx(1'b0, 13'h0000, 16'h0000);
    `CK(q[2], 1'b0)
    repeat (10) @(negedge clk);
    `CK(ready, 1'b0)
    wait_rdy(300);
    hx(1'b0, 13'h0123, 16'h0000);
    `CK(q, 16'h0000)
    hx(1'b0, 13'h0001, 16'h0000);
    `CK(q, 16'h0004)
    corrupt = 1'b1;
    mr(1'b0, 1'b0, 1'b0);
    wait_rdy(300);
    corrupt = 1'b0;
    hx(1'b0, 13'h0001, 16'h0000);
    `CK(q[1], 1'b1)
    // Soft reset clears config and the failure, and the RAM test runs again
    hx(1'b1, 13'h0000, 16'h000e);
    hx(1'b1, 13'h0001, 16'h0001);
    `CK(ready, 1'b0)
    wait_rdy(300);
    hx(1'b0, 13'h0000, 16'h0000);
    `CK(q, 16'h0000)
    hx(1'b0, 13'h0001, 16'h0000);
    `CK(q, 16'h0004)
    // Self-init from serial memory, then aborted by master reset
    mr(1'b1, 1'b1, 1'($urandom));
    for (i = 0; i < 3000 && trc_far_model_i.ram[4] !== ew(4); i++) @(negedge clk);
    if (trc_far_model_i.ram[4] !== ew(4)) timeout();
    `CK(ready, 1'b0)
    `CK(hdr, 24'h030000)
    `CK(tx_inhibit_a, 1'b1)
    for (int n = 2; n < 4; n++) `CK(trc_far_model_i.ram[n], ew(n))
    hx(1'b0, 13'h0000, 16'h0000);
    `CK(q[4], 1'b1)
    mr(1'b1, 1'b0, 1'b0);
    wait_rdy(20);
    `CK(ee_cs_n, 1'b1)
    stop_test();
  end
endmodule
`default_nettype wire
